// ==== pkg/pioc_pkg.sv ====
// constants for the port input/output configuration block
package pioc_pkg;

  // ---------------------------------------------------------------
  // register offsets on the special function register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT1_LATCH_OFF             = 8'h90;
  localparam logic [7:0] PORT1_CROSSBAR_SKIP_OFF     = 8'hd5;
  localparam logic [7:0] PORT1_OUTPUT_DRIVE_MODE_OFF = 8'ha5;
  localparam logic [7:0] PORT1_INPUT_ANALOG_SEL_OFF  = 8'hf2;
  localparam logic [7:0] PORT1_DRIVE_STRENGTH_OFF    = 8'ha9;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT1_LATCH_RST             = 8'hff;
  localparam logic [7:0] PORT1_CROSSBAR_SKIP_RST     = 8'h00;
  localparam logic [7:0] PORT1_OUTPUT_DRIVE_MODE_RST = 8'h00;
  localparam logic [7:0] PORT1_INPUT_ANALOG_SEL_RST  = 8'hff;
  localparam logic [7:0] PORT1_DRIVE_STRENGTH_RST    = 8'h00;
  localparam logic [7:0] READ_DATA_RST               = 8'h00;

  // ---------------------------------------------------------------
  // field values
  // ---------------------------------------------------------------
  localparam logic       INPUT_MODE_ANALOG  = 1'b0;
  localparam logic       INPUT_MODE_DIGITAL = 1'b1;
  localparam logic       OUTPUT_OPEN_DRAIN  = 1'b0;
  localparam logic       OUTPUT_PUSH_PULL   = 1'b1;
  localparam logic       DRIVE_LOW          = 1'b0;

endpackage

// ==== rtl/pioc_port.sv ====
// port input/output latch, readback and per-pin configuration
//
// Overview of operation
// - every port register is reachable as a byte and as single bits.
// - a write to the port register sets the output latch, which holds until the next write.
// - an ordinary read of the port register returns the pin levels, 0 for pins in analog mode, whatever the crossbar does.
// - read-modify-write and single-bit accesses read the latch, not the pins, then write back.
// - a per-pin skip bit set to 1 makes the crossbar pass over that pin.
// - an input mode bit of 0 selects analog mode and 1 keeps the pin digital.
// - analog mode disables weak pull-up and digital receiver but leaves the driver on.
// - crossbar assignment never changes input or output mode; software programs them.
// - digital-only pins cannot be put into analog mode.
// - an output mode bit of 0 means open-drain and 1 means push-pull.
// - the output mode bit still steers the driver while the pin is in analog mode.
// - two-wire serial bus pins always drive open-drain, whatever their output mode bit.
// - every pin has a drive strength bit, and all are low drive after reset.
// - bit n of each port register controls pin n, bit 7 the highest.
`timescale 1ns/100ps
module pioc_port #(
  parameter int         WIDTH        = 8,
  parameter logic [7:0] DIGITAL_ONLY = 8'h00
) (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // special function register bus
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic             sfr_rmw,
  input  wire logic             sfr_bit_en,
  input  wire logic [2:0]       sfr_bit_idx,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  output logic                  sfr_rbit,
  output logic                  sfr_rvalid,
  // crossbar side
  input  wire logic [WIDTH-1:0] xbar_sel,
  input  wire logic [WIDTH-1:0] xbar_out,
  input  wire logic [WIDTH-1:0] smbus_sel,
  output logic      [WIDTH-1:0] port_crossbar_skip,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup_en,
  output logic      [WIDTH-1:0] pin_rx_en,
  output logic      [WIDTH-1:0] port_drive_strength
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic [WIDTH-1:0] reg_update(
    input logic [WIDTH-1:0] cur,
    input logic             bit_en,
    input logic [2:0]       idx,
    input logic [7:0]       wdata
  );
    logic [WIDTH-1:0] v;
    v = cur;
    if (bit_en) begin
      v[idx] = wdata[0];
    end else begin
      v = wdata[WIDTH-1:0];
    end
    reg_update = v;
  endfunction

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] latch_nxt;
  logic [WIDTH-1:0] skip_r;
  logic [WIDTH-1:0] skip_nxt;
  logic [WIDTH-1:0] mdout_r;
  logic [WIDTH-1:0] mdout_nxt;
  logic [WIDTH-1:0] mdin_r;
  logic [WIDTH-1:0] mdin_nxt;
  logic [WIDTH-1:0] drv_r;
  logic [WIDTH-1:0] drv_nxt;
  logic [WIDTH-1:0] mdin_eff;
  logic [WIDTH-1:0] pin_seen;

  // digital-only pins read as digital mode
  assign mdin_eff = mdin_r | DIGITAL_ONLY[WIDTH-1:0];
  // receiver off in analog mode
  assign pin_seen = pin_in & mdin_eff;

  always_comb begin
    latch_nxt = latch_r;
    skip_nxt  = skip_r;
    mdout_nxt = mdout_r;
    mdin_nxt  = mdin_r;
    drv_nxt   = drv_r;
    if (sfr_wr) begin
      // bit writes merge into the stored value, never the pins
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_LATCH_OFF)) begin
        latch_nxt = reg_update(latch_r, sfr_bit_en, sfr_bit_idx, sfr_wdata);
      end
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_CROSSBAR_SKIP_OFF)) begin
        skip_nxt = reg_update(skip_r, sfr_bit_en, sfr_bit_idx, sfr_wdata);
      end
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_OFF)) begin
        mdout_nxt = reg_update(mdout_r, sfr_bit_en, sfr_bit_idx, sfr_wdata);
      end
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_INPUT_ANALOG_SEL_OFF)) begin
        mdin_nxt = reg_update(mdin_r, sfr_bit_en, sfr_bit_idx, sfr_wdata);
      end
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_DRIVE_STRENGTH_OFF)) begin
        drv_nxt = reg_update(drv_r, sfr_bit_en, sfr_bit_idx, sfr_wdata);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= pioc_pkg::PORT1_LATCH_RST[WIDTH-1:0];
      skip_r  <= pioc_pkg::PORT1_CROSSBAR_SKIP_RST[WIDTH-1:0];
      mdout_r <= pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_RST[WIDTH-1:0];
      mdin_r  <= pioc_pkg::PORT1_INPUT_ANALOG_SEL_RST[WIDTH-1:0];
      drv_r   <= pioc_pkg::PORT1_DRIVE_STRENGTH_RST[WIDTH-1:0];
    end else if (ce) begin
      latch_r <= latch_nxt;
      skip_r  <= skip_nxt;
      mdout_r <= mdout_nxt;
      mdin_r  <= mdin_nxt;
      drv_r   <= drv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic       rbit_nxt;
  logic       rvalid_nxt;
  logic [7:0] rdata_r;
  logic       rbit_r;
  logic       rvalid_r;

  always_comb begin
    rdata_nxt  = pioc_pkg::READ_DATA_RST;
    rvalid_nxt = sfr_rd;
    if (sfr_rd) begin
      if (reg_hit(sfr_addr, pioc_pkg::PORT1_LATCH_OFF)) begin
        if (sfr_rmw || sfr_bit_en) begin
          rdata_nxt[WIDTH-1:0] = latch_r;
        end else begin
          rdata_nxt[WIDTH-1:0] = pin_seen;
        end
      end else if (reg_hit(sfr_addr, pioc_pkg::PORT1_CROSSBAR_SKIP_OFF)) begin
        rdata_nxt[WIDTH-1:0] = skip_r;
      end else if (reg_hit(sfr_addr, pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_OFF)) begin
        rdata_nxt[WIDTH-1:0] = mdout_r;
      end else if (reg_hit(sfr_addr, pioc_pkg::PORT1_INPUT_ANALOG_SEL_OFF)) begin
        rdata_nxt[WIDTH-1:0] = mdin_eff;
      end else if (reg_hit(sfr_addr, pioc_pkg::PORT1_DRIVE_STRENGTH_OFF)) begin
        rdata_nxt[WIDTH-1:0] = drv_r;
      end
    end
    rbit_nxt = rdata_nxt[sfr_bit_idx];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r  <= pioc_pkg::READ_DATA_RST;
      rbit_r   <= 1'b0;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rdata_r  <= rdata_nxt;
      rbit_r   <= rbit_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign sfr_rdata  = rdata_r;
  assign sfr_rbit   = rbit_r;
  assign sfr_rvalid = rvalid_r;

  // ---------------------------------------------------------------
  // pin drivers, one cell per pin
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] out_nxt;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] oe_r;
  logic [WIDTH-1:0] pull_r;
  logic [WIDTH-1:0] rx_r;
  logic [WIDTH-1:0] pp_eff;
  logic [WIDTH-1:0] src_all;

  // mode bits are never touched by xbar_sel; smbus_sel pins are forced open-drain
  assign pp_eff = mdout_r & ~smbus_sel;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic push;
      // bit g steers pin g
      assign src_all[g] = xbar_sel[g] ? xbar_out[g] : latch_r[g];
      assign push       = (pp_eff[g] == pioc_pkg::OUTPUT_PUSH_PULL);
      // open-drain pins only ever pull low
      assign out_nxt[g] = push ? src_all[g] : 1'b0;
      assign oe_nxt[g]  = push ? 1'b1 : ~src_all[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_r  <= '0;
      oe_r   <= '0;
      pull_r <= '0;
      rx_r   <= '0;
    end else if (ce) begin
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
      pull_r <= mdin_eff;
      rx_r   <= mdin_eff;
    end
  end

  assign pin_out             = out_r;
  assign pin_oe              = oe_r;
  assign pin_pullup_en       = pull_r;
  assign pin_rx_en           = rx_r;
  assign port_crossbar_skip  = skip_r;
  assign port_drive_strength = drv_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_latch_byte_wr: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sfr_wr && !sfr_bit_en && sfr_addr == pioc_pkg::PORT1_LATCH_OFF
      |=> latch_r == $past(sfr_wdata[WIDTH-1:0]))
    else $error("latch byte write not stored");

  a_latch_bit_wr: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sfr_wr && sfr_bit_en && sfr_addr == pioc_pkg::PORT1_LATCH_OFF
      |=> (latch_r ^ $past(latch_r)) == (({{(WIDTH-1){1'b0}}, 1'b1} << $past(sfr_bit_idx))
          & ({WIDTH{$past(sfr_wdata[0])}} ^ $past(latch_r))))
    else $error("bit write disturbed other latch bits");

  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(sfr_wr && sfr_addr == pioc_pkg::PORT1_LATCH_OFF) |=> $stable(latch_r))
    else $error("latch changed without a write");

  a_pin_readback: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sfr_rd && !sfr_rmw && !sfr_bit_en && sfr_addr == pioc_pkg::PORT1_LATCH_OFF
      |=> sfr_rvalid && sfr_rdata[WIDTH-1:0] == $past(pin_in & mdin_eff))
    else $error("port read did not return pins");

  a_rmw_readback: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sfr_rd && sfr_rmw && sfr_addr == pioc_pkg::PORT1_LATCH_OFF
      |=> sfr_rdata[WIDTH-1:0] == $past(latch_r))
    else $error("read-modify-write read did not return latch");

  a_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> (pin_out & ~$past(pp_eff)) == '0
      && ((pin_oe ^ ~$past(src_all)) & ~$past(pp_eff)) == '0)
    else $error("open-drain pin drove high");

  a_smbus_od: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> (pin_oe & pin_out & $past(smbus_sel)) == '0)
    else $error("serial bus pin drove high");

  a_pp_drive: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> (~pin_oe & $past(pp_eff)) == '0
      && ((pin_out ^ $past(src_all)) & $past(pp_eff)) == '0)
    else $error("push-pull pin not driven");

  a_analog_pull: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> (pin_pullup_en | pin_rx_en) == $past(mdin_eff))
    else $error("analog pin kept pull-up or receiver");

  a_bit_read: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b && sfr_rd |=> sfr_rbit == sfr_rdata[$past(sfr_bit_idx)])
    else $error("bit read differs from byte read");

  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    !ce && rst_b |=> $stable(latch_r) && $stable(pin_out) && $stable(pin_oe))
    else $error("state moved while clock enable low");

  a_digital_only: assert property (@(posedge clk) disable iff (!rst_b)
    (mdin_eff & DIGITAL_ONLY[WIDTH-1:0]) == DIGITAL_ONLY[WIDTH-1:0])
    else $error("digital-only pin in analog mode");

  a_skip_wr: assert property (@(posedge clk) disable iff (!rst_b)
    ce && sfr_wr && !sfr_bit_en && sfr_addr == pioc_pkg::PORT1_CROSSBAR_SKIP_OFF
      |=> port_crossbar_skip == $past(sfr_wdata[WIDTH-1:0]))
    else $error("skip write not seen at output");

endmodule

// ==== verification/pioc_board_model.sv ====
// board-side model of the port pins: pull-ups, external drivers, floating nets
`timescale 1ns/100ps
module pioc_board_model (
  // clock
  input  wire logic       clk,
  // device pin drivers
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  // external drivers on the board
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // sensed level
  output logic      [7:0] pin_in
);
  logic [7:0] float_r;

  initial float_r = 8'h55;
  // undriven pins wander every cycle
  always @(posedge clk) float_r <= ~float_r;

  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (pin_oe[n]) pin_in[n] = pin_out[n];
      else if (ext_en[n]) pin_in[n] = ext_val[n];
      else if (pin_pullup_en[n]) pin_in[n] = 1'b1;
      else pin_in[n] = float_r[n];
    end
  end
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the port input/output configuration block
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] DIG_ONLY = 8'h80;
  logic       clk, rst_b, ce, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_en, sfr_rbit, sfr_rvalid;
  logic [2:0] sfr_bit_idx;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xbar_sel, xbar_out, smbus_sel, skip, pin_in;
  logic [7:0] pin_out, pin_oe, pin_pullup_en, pin_rx_en, drv, ext_en, ext_val;
  logic [7:0] m, i, v, src, pp, oe, pin;
  int         fail_count, n_checks;

  pioc_port #(.WIDTH(8), .DIGITAL_ONLY(DIG_ONLY)) i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_bit_en(sfr_bit_en), .sfr_bit_idx(sfr_bit_idx),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rbit(sfr_rbit),
    .sfr_rvalid(sfr_rvalid), .xbar_sel(xbar_sel), .xbar_out(xbar_out),
    .smbus_sel(smbus_sel), .port_crossbar_skip(skip), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_rx_en(pin_rx_en),
    .port_drive_strength(drv));

  pioc_board_model i_board (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one register access, request held until the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic rmw, input logic be, input logic [2:0] k);
    @(posedge clk);
    sfr_wr      <= w;
    sfr_rd      <= ~w;
    sfr_addr    <= a;
    sfr_wdata   <= d;
    sfr_rmw     <= rmw;
    sfr_bit_en  <= be;
    sfr_bit_idx <= k;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic be = 1'b0,
                    input logic [2:0] k = 3'h0);
    acc(1'b1, a, d, 1'b0, be, k);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp,
                    input logic rmw = 1'b0, input logic be = 1'b0, input logic [2:0] k = 3'h0);
    acc(1'b0, a, 8'h00, rmw, be, k);
    chk("read valid", {7'h00, sfr_rvalid}, 8'h01);
    chk(nm, sfr_rdata, exp);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    {rst_b, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_en, sfr_bit_idx} = '0;
    {sfr_addr, sfr_wdata, xbar_sel, xbar_out, smbus_sel, ext_en, ext_val} = '0;
    ce = 1'b1;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(86994));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    chk("drive strength", drv, 8'h00);
    rd("out mode", pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_OFF, 8'h00);
    rd("in mode", pioc_pkg::PORT1_INPUT_ANALOG_SEL_OFF, 8'hff);
    rd("skip", pioc_pkg::PORT1_CROSSBAR_SKIP_OFF, 8'h00);
    rd("drive reg", pioc_pkg::PORT1_DRIVE_STRENGTH_OFF, 8'h00);
    rd("latch", pioc_pkg::PORT1_LATCH_OFF, 8'hff, 1'b1);
    rd("unmapped", 8'h00, 8'h00);
    $display("test reset values done");
    for (int t = 0; t < 40; t++) begin
      m = $urandom;
      i = $urandom;
      v = $urandom;
      @(posedge clk);
      xbar_sel  <= $urandom;
      xbar_out  <= $urandom;
      smbus_sel <= $urandom;
      ext_en    <= $urandom;
      ext_val   <= $urandom;
      wr(pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_OFF, m);
      wr(pioc_pkg::PORT1_INPUT_ANALOG_SEL_OFF, i);
      wr(pioc_pkg::PORT1_LATCH_OFF, v);
      @(posedge clk);
      #1;
      i   = i | DIG_ONLY;
      src = (xbar_sel & xbar_out) | (~xbar_sel & v);
      pp  = m & ~smbus_sel;
      oe  = pp | ~src;
      pin = (oe & pp & src) | (~oe & ~(ext_en & ~ext_val));
      chk("pin enable", pin_oe, oe);
      chk("pin value", pin_out, pp & src);
      chk("pull-up", pin_pullup_en, i);
      chk("receiver", pin_rx_en, i);
      rd("port pins", pioc_pkg::PORT1_LATCH_OFF, pin & i);
      rd("port latch", pioc_pkg::PORT1_LATCH_OFF, v, 1'b1);
      rd("in mode", pioc_pkg::PORT1_INPUT_ANALOG_SEL_OFF, i);
      rd("out mode", pioc_pkg::PORT1_OUTPUT_DRIVE_MODE_OFF, m);
    end
    $display("test pin modes done");
    for (int k = 0; k < 8; k++) begin
      v[k] = ~v[k];
      wr(pioc_pkg::PORT1_LATCH_OFF, {7'h00, v[k]}, 1'b1, k[2:0]);
      rd("bit latch", pioc_pkg::PORT1_LATCH_OFF, v, 1'b0, 1'b1, k[2:0]);
      chk("bit read", {7'h00, sfr_rbit}, {7'h00, v[k]});
    end
    $display("test bit access done");
    v = $urandom;
    m = $urandom;
    wr(pioc_pkg::PORT1_CROSSBAR_SKIP_OFF, v);
    wr(pioc_pkg::PORT1_DRIVE_STRENGTH_OFF, m);
    @(posedge clk);
    #1;
    chk("skip out", skip, v);
    chk("drive out", drv, m);
    rd("skip", pioc_pkg::PORT1_CROSSBAR_SKIP_OFF, v);
    $display("test skip and drive done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd("latch after reset", pioc_pkg::PORT1_LATCH_OFF, pioc_pkg::PORT1_LATCH_RST, 1'b1);
    chk("pull-up after reset", pin_pullup_en, 8'hff);
    @(posedge clk);
    ce <= 1'b0;
    wr(pioc_pkg::PORT1_LATCH_OFF, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rd("latch frozen", pioc_pkg::PORT1_LATCH_OFF, pioc_pkg::PORT1_LATCH_RST, 1'b1);
    $display("test reset and clock enable done");
    summarize();
  end
endmodule
